// ===== rtl/ieh_host_port.sv
// four-port 1284 host controller: registers, compatibility engine, latch multiplexer
// assumes external data/control latches per port on one shared bus, inputs synchronous
`timescale 1ns/1ps

module ieh_host_port
   import ieh_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic [3:0]          addr,
   input  wire logic [15:0]         wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output logic      [15:0]         rdata,
   input  wire logic                dma_wr,
   input  wire ieh_dma_t            dma,
   output logic      [NPORT-1:0]    dma_req,
   output logic                     irq,
   input  wire ieh_stat_in_t        stat_in [NPORT],
   input  wire logic [7:0]          shared_port_bus_i,
   output logic      [7:0]          shared_port_bus_o,
   output logic                     shared_port_bus_oe,
   output logic      [NPORT-1:0]    data_latch_clock,
   output logic      [NPORT-1:0]    control_latch_clock,
   output logic      [NPORT-1:0]    port_read_enable_n
);

   // automatic engine phases, and the slots of one port visit on the shared bus
   typedef enum {A_IDLE, A_SETUP, A_STROBE, A_HOLD} ieh_auto_t;
   typedef enum {S_DSET, S_DCLK, S_DHLD, S_CSET, S_CCLK, S_CHLD,
                 S_RFLT, S_REN, S_RGAP} ieh_slot_t;

   // per-port software state, inbound byte and engine timers
   logic [15:0]  ctrl_ff   [NPORT];
   logic [7:0]   data_ff   [NPORT];
   logic [7:0]   inb_ff    [NPORT];
   logic [10:0]  width_ff  [NPORT];
   logic [10:0]  tmr_ff    [NPORT];
   logic [1:0]   blow_ff   [NPORT];
   ieh_auto_t    ap_ff     [NPORT];
   logic [NPORT-1:0] obe_ff;
   logic [NPORT-1:0] ackf_ff;
   logic [NPORT-1:0] ackp_ff;
   ieh_slot_t    slot_ff;
   ieh_slot_t    nxt_slot;
   logic [1:0]   cur_ff;
   logic [1:0]   nxt_cur;
   ieh_mode_t    mode     [NPORT];
   logic [NPORT-1:0] is_auto;
   logic [NPORT-1:0] dma_ok;
   logic [NPORT-1:0] load;
   logic [7:0]   load_val [NPORT];
   logic [NPORT-1:0] strobe_n;
   logic [1:0]   a_port;
   logic [1:0]   a_reg;

   // register bus address: port in the upper two bits, index below
   assign a_port = addr[3:2];
   assign a_reg  = addr[1:0];

   // mode code to mode
   // codes outside the table decode to a dead mode with no dma and no engine
   function automatic ieh_mode_t decode(input logic [3:0] m);
      case (m)
         MODE_MAN_COMPAT:  decode = IEH_M_MAN_COMPAT;
         MODE_AUTO_COMPAT: decode = IEH_M_AUTO_COMPAT;
         MODE_BYTE:        decode = IEH_M_BYTE;
         MODE_ECP_FWD:     decode = IEH_M_ECP_FWD;
         MODE_ECP_REV:     decode = IEH_M_ECP_REV;
         MODE_EPP:         decode = IEH_M_EPP;
         default:          decode = IEH_M_BAD;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // per-port decode and load requests from cpu and dma
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         mode[p]    = decode(ctrl_ff[p][3:0]);
         is_auto[p] = mode[p] == IEH_M_AUTO_COMPAT;
         dma_ok[p]  = (mode[p] == IEH_M_AUTO_COMPAT) || (mode[p] == IEH_M_MAN_COMPAT) ||
                      (mode[p] == IEH_M_ECP_FWD) || (mode[p] == IEH_M_ECP_REV);
         // a refused cpu write is dropped silently; software polls outbound-empty first
         // auto mode refuses loads until empty so the hold phase stays intact
         load[p]     = 1'b0;
         load_val[p] = data_ff[p];
         if (wr && a_reg == REG_DATA && a_port == 2'(p) && (obe_ff[p] || !is_auto[p])) begin
            load[p]     = 1'b1;
            load_val[p] = wdata[7:0];
         end else if (dma_wr && dma.port == 2'(p) && dma_ok[p] && obe_ff[p] &&
                      ctrl_ff[p][CB_DMA_REQUEST_ENABLE]) begin
            load[p]     = 1'b1;
            load_val[p] = dma.data;
         end
         // manual strobe bit outside the automatic engine
         strobe_n[p] = is_auto[p] ? (ap_ff[p] != A_STROBE) : ctrl_ff[p][CB_MANUAL_STROBE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software registers
   // widths outside the legal range are clamped, not refused, so timing never stalls
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NPORT; p++) begin
            ctrl_ff[p]  <= CTRL_RST;
            width_ff[p] <= STB_MIN_CYC;
         end
      end else if (wr) begin
         if (a_reg == REG_CTRL)
            ctrl_ff[a_port] <= wdata;
         if (a_reg == REG_WIDTH) begin
            if (wdata[10:0] < STB_MIN_CYC)
               width_ff[a_port] <= STB_MIN_CYC;
            else if (wdata[10:0] > STB_MAX_CYC)
               width_ff[a_port] <= STB_MAX_CYC;
            else
               width_ff[a_port] <= wdata[10:0];
         end
      end
   end

   // channel data registers hold the last byte loaded
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NPORT; p++)
            data_ff[p] <= 8'h00;
      end else begin
         for (int p = 0; p < NPORT; p++)
            if (load[p])
               data_ff[p] <= load_val[p];
      end
   end

   // acknowledge falling edge flags; a new edge beats a clear in the same cycle
   // irq is a plain level one cycle behind the flags; masking is left to the system
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ackf_ff <= '0;
         ackp_ff <= '1;
         irq     <= 1'b0;
      end else begin
         for (int p = 0; p < NPORT; p++) begin
            ackp_ff[p] <= stat_in[p].ack_n;
            if (ctrl_ff[p][CB_ACKIE] && ackp_ff[p] && !stat_in[p].ack_n)
               ackf_ff[p] <= 1'b1;
            else if (wr && a_reg == REG_STAT && a_port == 2'(p) && wdata[ST_ACKF])
               ackf_ff[p] <= 1'b0;
         end
         irq <= |ackf_ff;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         rdata <= 16'h0000;
      else if (rd) begin
         case (a_reg)
            REG_CTRL:  rdata <= ctrl_ff[a_port];
            REG_DATA:  rdata <= {8'h00, inb_ff[a_port]};
            REG_STAT:  rdata <= {9'h000, ackf_ff[a_port], obe_ff[a_port],
                                 stat_in[a_port].ack_n, stat_in[a_port].fault_n,
                                 stat_in[a_port].peripheral_select, stat_in[a_port].pe,
                                 stat_in[a_port].busy};
            REG_WIDTH: rdata <= {5'h00, width_ff[a_port]};
            default:   rdata <= 16'h0000;
         endcase
      end else
         rdata <= 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // automatic compatibility engine, one per port
   // each phase adds one rotation so the latched strobe keeps its minimum width
   // the fast timing bit is stored only; both settings run the slow sequence
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NPORT; p++) begin
            ap_ff[p]   <= A_IDLE;
            tmr_ff[p]  <= 11'h000;
            blow_ff[p] <= 2'h0;
         end
         obe_ff <= '1;
      end else begin
         for (int p = 0; p < NPORT; p++) begin
            // count busy-low cycles, saturating
            if (stat_in[p].busy)
               blow_ff[p] <= 2'h0;
            else if (blow_ff[p] != BUSY_LOW_CYC)
               blow_ff[p] <= blow_ff[p] + 2'h1;
            if (!is_auto[p]) begin
               ap_ff[p]  <= A_IDLE;
               obe_ff[p] <= 1'b1;
            end else begin
               case (ap_ff[p])
                  A_IDLE: begin
                     if (load[p]) begin
                        ap_ff[p]  <= A_SETUP;
                        tmr_ff[p] <= width_ff[p] + ROT_CYC;
                        obe_ff[p] <= 1'b0;
                     end
                  end
                  A_SETUP: begin
                     if (tmr_ff[p] == 11'h000) begin
                        ap_ff[p]  <= A_STROBE;
                        tmr_ff[p] <= width_ff[p] + ROT_CYC;
                     end else
                        tmr_ff[p] <= tmr_ff[p] - 11'h001;
                  end
                  A_STROBE: begin
                     if (tmr_ff[p] == 11'h000) begin
                        ap_ff[p]  <= A_HOLD;
                        tmr_ff[p] <= width_ff[p] + ROT_CYC;
                     end else
                        tmr_ff[p] <= tmr_ff[p] - 11'h001;
                  end
                  A_HOLD: begin
                     if (tmr_ff[p] != 11'h000)
                        tmr_ff[p] <= tmr_ff[p] - 11'h001;
                     else if (blow_ff[p] == BUSY_LOW_CYC) begin
                        ap_ff[p]  <= A_IDLE;
                        obe_ff[p] <= 1'b1;
                     end
                  end
                  default: ap_ff[p] <= A_IDLE;
               endcase
            end
         end
      end
   end

   // dma requests only where the mode supports it and the register is empty
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         dma_req <= '0;
      else
         for (int p = 0; p < NPORT; p++)
            dma_req[p] <= ctrl_ff[p][CB_DMA_REQUEST_ENABLE] && dma_ok[p] && obe_ff[p] && !load[p];
   end

   ////////////////////////////////////////////////////////////////////////////
   // round-robin latch multiplexer
   // a visit is six slots, nine when the port has its reverse bit set
   always_comb begin
      nxt_slot = slot_ff;
      nxt_cur  = cur_ff;
      case (slot_ff)
         S_DSET: nxt_slot = S_DCLK;
         S_DCLK: nxt_slot = S_DHLD;
         S_DHLD: nxt_slot = S_CSET;
         S_CSET: nxt_slot = S_CCLK;
         S_CCLK: nxt_slot = S_CHLD;
         S_CHLD: begin
            if (ctrl_ff[cur_ff][CB_REV])
               nxt_slot = S_RFLT;
            else begin
               nxt_slot = S_DSET;
               nxt_cur  = cur_ff + 2'h1;
            end
         end
         S_RFLT: nxt_slot = S_REN;
         S_REN:  nxt_slot = S_RGAP;
         S_RGAP: begin
            nxt_slot = S_DSET;
            nxt_cur  = cur_ff + 2'h1;
         end
         default: nxt_slot = S_DSET;
      endcase
   end

   // pin flops follow the slot being entered, so they line up with it
   // read enable is low only in the read slot, with the bus floated on both sides
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         // start as the read gap of the last port, so the first edge enters a
         // data setup of port 0 and the bus is driven a cycle before its clock
         slot_ff             <= S_RGAP;
         cur_ff              <= 2'h3;
         shared_port_bus_o   <= 8'h00;
         shared_port_bus_oe  <= 1'b0;
         data_latch_clock    <= '0;
         control_latch_clock <= '0;
         port_read_enable_n  <= '1;
      end else begin
         slot_ff <= nxt_slot;
         cur_ff  <= nxt_cur;
         // a byte is frozen for the whole setup, clock and hold of its latch
         if (nxt_slot == S_DSET)
            shared_port_bus_o <= data_ff[nxt_cur];
         else if (nxt_slot == S_CSET)
            shared_port_bus_o <= {strobe_n[nxt_cur],
                                  ctrl_ff[nxt_cur][CB_AFD],
                                  ctrl_ff[nxt_cur][CB_INIT],
                                  ctrl_ff[nxt_cur][CB_HSEL],
                                  ctrl_ff[nxt_cur][CB_REV],
                                  ctrl_ff[nxt_cur][CB_PIO],
                                  ctrl_ff[nxt_cur][CB_LOOP],
                                  !strobe_n[nxt_cur]};
         shared_port_bus_oe <= !(nxt_slot == S_RFLT || nxt_slot == S_REN ||
                                 nxt_slot == S_RGAP);
         // one-hot of a single port, so never two latch clocks at once
         data_latch_clock    <= (nxt_slot == S_DCLK) ? NPORT'(1) << nxt_cur : '0;
         control_latch_clock <= (nxt_slot == S_CCLK) ? NPORT'(1) << nxt_cur : '0;
         port_read_enable_n  <= (nxt_slot == S_REN) ? ~(NPORT'(1) << nxt_cur) : '1;
      end
   end

   // capture inbound byte while the port enable is low
   // the bus is sampled at the end of the read slot, when the transceiver has settled
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NPORT; p++)
            inb_ff[p] <= 8'h00;
      end else if (slot_ff == S_REN)
         inb_ff[cur_ff] <= shared_port_bus_i;
   end

endmodule

// ===== rtl/ieh_pkg.sv
// constants, field layouts and carrier types for the four-port 1284 host block
// assumes a 125 MHz system clock; register map is per port, four words each
package ieh_pkg;
   localparam int CLK_NS     = 8;       // system clock period
   localparam int STB_MIN_NS = 500;     // shortest strobe width
   localparam int STB_MAX_NS = 10000;   // longest strobe width
   localparam logic [10:0] STB_MIN_CYC = 11'((STB_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [10:0] STB_MAX_CYC = 11'(STB_MAX_NS / CLK_NS);
   localparam logic [1:0]  BUSY_LOW_CYC = 2'h3;   // busy low before data may change
   localparam int NPORT    = 4;
   localparam int SLOT_LEN = 9;                   // worst-case cycles per port visit
   localparam logic [10:0] ROT_CYC = 11'(NPORT * SLOT_LEN);

   // register index within a port: addr = {port, index}
   localparam logic [1:0] REG_CTRL  = 2'h0;
   localparam logic [1:0] REG_DATA  = 2'h1;
   localparam logic [1:0] REG_STAT  = 2'h2;
   localparam logic [1:0] REG_WIDTH = 2'h3;

   // port control register bits; [3:0] is the mode code
   localparam int CB_MAN   = 0;
   localparam int CB_REV   = 1;
   localparam int CB_ECP   = 2;
   localparam int CB_EPP   = 3;
   localparam int CB_FAST  = 4;
   localparam int CB_DMA_REQUEST_ENABLE  = 5;
   localparam int CB_MANUAL_STROBE_BIT  = 6;
   localparam int CB_AFD   = 7;
   localparam int CB_INIT  = 8;
   localparam int CB_HSEL  = 9;
   localparam int CB_PIO   = 10;
   localparam int CB_LOOP  = 11;
   localparam int CB_ACKIE = 12;
   localparam logic [15:0] CTRL_RST = 16'h03C0;   // active-low outputs idle high

   // status register bits
   localparam int ST_BUSY  = 0;
   localparam int ST_PE    = 1;
   localparam int ST_PSEL  = 2;
   localparam int ST_FAULT = 3;
   localparam int ST_ACK   = 4;
   localparam int ST_OBE   = 5;
   localparam int ST_ACKF  = 6;

   // mode codes {epp, ecp, reverse_direction, manual_select}
   localparam logic [3:0] MODE_MAN_COMPAT  = 4'h1;
   localparam logic [3:0] MODE_AUTO_COMPAT = 4'h0;
   localparam logic [3:0] MODE_BYTE        = 4'h3;
   localparam logic [3:0] MODE_ECP_FWD     = 4'h4;
   localparam logic [3:0] MODE_ECP_REV     = 4'h6;
   localparam logic [3:0] MODE_EPP         = 4'hA;

   typedef enum {
      IEH_M_MAN_COMPAT, IEH_M_AUTO_COMPAT, IEH_M_BYTE, IEH_M_ECP_FWD,
      IEH_M_ECP_REV, IEH_M_EPP, IEH_M_BAD
   } ieh_mode_t;

   // cable status inputs of one port
   typedef struct packed {
      logic ack_n;
      logic busy;
      logic pe;
      logic peripheral_select;
      logic fault_n;
   } ieh_stat_in_t;

   // one dma write into a channel data register
   typedef struct packed {
      logic [1:0] port;
      logic [7:0] data;
   } ieh_dma_t;
endpackage

// ===== dv/ieh_host_port_properties.sv
// concurrent checks on the latch multiplexer of the four-port host block
// assumes it is bound to ieh_host_port and sees only that module's ports
`timescale 1ns/1ps

module ieh_host_port_properties
   import ieh_pkg::*;
(
   input wire logic             ref_clk,
   input wire logic             rst,
   input wire logic             rd,
   input wire logic             dma_wr,
   input wire logic [7:0]       shared_port_bus_o,
   input wire logic             shared_port_bus_oe,
   input wire logic [NPORT-1:0] data_latch_clock,
   input wire logic [NPORT-1:0] control_latch_clock,
   input wire logic [NPORT-1:0] port_read_enable_n
);
   logic [7:0] clks;
   logic       all_off;

   // merged views of the latch clocks and read enables
   assign clks    = {data_latch_clock, control_latch_clock};
   assign all_off = &port_read_enable_n;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////////
   one_latch_a: assert property ($onehot0(clks))
      else $error("two latch clocks high together");
   latch_width_a: assert property (|clks |=> clks == 8'h00)
      else $error("latch clock high longer than one cycle");
   latch_setup_a: assert property (|clks |->
      shared_port_bus_oe && $past(shared_port_bus_oe) && $stable(shared_port_bus_o))
      else $error("bus not settled before latch clock");
   latch_hold_a: assert property (|clks |=>
      shared_port_bus_oe && $stable(shared_port_bus_o))
      else $error("bus changed right after latch clock");
   ctrl_after_data_a: assert property (|data_latch_clock |->
      ##3 control_latch_clock == $past(data_latch_clock, 3))
      else $error("control latch of same port not three cycles after data");
   robin_next_a: assert property (control_latch_clock[0] |-> ##[3:6] data_latch_clock[1])
      else $error("port one not visited after port zero");
   bus_float_a: assert property (!all_off |->
      !shared_port_bus_oe && !$past(shared_port_bus_oe))
      else $error("bus driven around read enable");
   bus_redrive_a: assert property (!$past(all_off) |-> !shared_port_bus_oe)
      else $error("bus driven too soon after read enable");
   read_pulse_a: assert property (!all_off |->
      $onehot0(~port_read_enable_n) ##1 all_off)
      else $error("read enable not a single one-cycle pulse");

   // main scenarios reached
   cover property (rd);
   cover property (dma_wr);
   cover property (!all_off);
endmodule

bind ieh_host_port ieh_host_port_properties u_props (
   .ref_clk(ref_clk), .rst(rst), .rd(rd), .dma_wr(dma_wr),
   .shared_port_bus_o(shared_port_bus_o), .shared_port_bus_oe(shared_port_bus_oe),
   .data_latch_clock(data_latch_clock), .control_latch_clock(control_latch_clock),
   .port_read_enable_n(port_read_enable_n));

// ===== dv/ieh_far_side.sv
// external latches and a slow peripheral for each of the four ports
// assumes latch clocks and read enables come from the host block, one clock domain
`timescale 1ns/1ps

module ieh_far_side
   import ieh_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic [7:0]    shared_port_bus_o,
   input  wire logic [3:0]    data_latch_clock,
   input  wire logic [3:0]    control_latch_clock,
   input  wire logic [3:0]    port_read_enable_n,
   input  wire logic [7:0]    in_byte,
   input  wire logic [7:0]    busy_len,
   input  wire ieh_stat_in_t  stat_base [NPORT],
   output logic      [7:0]    shared_port_bus_i,
   output ieh_stat_in_t       stat_in [NPORT],
   output logic      [7:0]    data_ff [NPORT],
   output logic      [7:0]    ctrl_ff [NPORT]
);
   logic [7:0] last_ff;
   logic [7:0] busy_cnt_ff [NPORT];

   // latches load the shared bus on their own clock; busy starts at strobe fall
   always_ff @(posedge ref_clk or posedge rst) begin
      for (int p = 0; p < NPORT; p++) begin
         if (rst) begin
            busy_cnt_ff[p] <= 8'h00;
         end else begin
            if (data_latch_clock[p]) data_ff[p] <= shared_port_bus_o;
            if (control_latch_clock[p]) ctrl_ff[p] <= shared_port_bus_o;
            if (control_latch_clock[p] && !shared_port_bus_o[7] && ctrl_ff[p][7] !== 1'b0)
               busy_cnt_ff[p] <= busy_len;
            else if (busy_cnt_ff[p] != 8'h00)
               busy_cnt_ff[p] <= busy_cnt_ff[p] - 8'h01;
         end
      end
   end

   // status lines in, busy from the peripheral's own pacing
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         stat_in[p]      = stat_base[p];
         stat_in[p].busy = busy_cnt_ff[p] != 8'h00;
      end
   end

   // unselected transceivers leave the bus wandering, never a stale value
   assign shared_port_bus_i = (&port_read_enable_n) ? ~last_ff : in_byte;
   always_ff @(posedge ref_clk) begin
      last_ff <= shared_port_bus_i;
   end
endmodule

// ===== dv/tb_ieh_host_port.sv
// self-checking bench for the four-port host block with latch and peripheral model
// assumes 125 MHz clock; expectations come from bench functions, bench tables and package constants
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end

module tb_ieh_host_port;
   import ieh_pkg::*;
   logic         ref_clk, rst, wr, rd, dma_wr, irq;
   logic [3:0]   addr, dma_req;
   logic [15:0]  wdata, rdata, v, c;
   ieh_dma_t     dma;
   ieh_stat_in_t stat_base [NPORT];
   ieh_stat_in_t stat_in [NPORT];
   logic [7:0]   bus_i, bus_o, in_byte, busy_len, b1;
   logic [3:0]   dlc, clc, ren_n;
   logic [31:0]  rnd;
   int           bad_count, comparisons, n;
   logic [3:0]   codes [6] = '{MODE_AUTO_COMPAT, MODE_MAN_COMPAT, MODE_BYTE,
                               MODE_ECP_FWD, MODE_ECP_REV, MODE_EPP};
   localparam logic [5:0] DMA_EXP = 6'b011011;   // dma offered per entry of codes, lsb first

   ieh_host_port u_ieh_host_port (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .dma_wr(dma_wr), .dma(dma), .dma_req(dma_req),
      .irq(irq), .stat_in(stat_in), .shared_port_bus_i(bus_i), .shared_port_bus_o(bus_o),
      .shared_port_bus_oe(), .data_latch_clock(dlc), .control_latch_clock(clc),
      .port_read_enable_n(ren_n));
   ieh_far_side u_far (.ref_clk(ref_clk), .rst(rst), .shared_port_bus_o(bus_o),
      .data_latch_clock(dlc), .control_latch_clock(clc), .port_read_enable_n(ren_n),
      .in_byte(in_byte), .busy_len(busy_len), .stat_base(stat_base),
      .shared_port_bus_i(bus_i), .stat_in(stat_in), .data_ff(), .ctrl_ff());

   ////////////////////////////////////////////////////////////////////////////////
   // pseudo-random source, control byte the latch should hold
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] ctrl_byte(logic [15:0] k);
      return {k[CB_MANUAL_STROBE_BIT], k[CB_AFD], k[CB_INIT], k[CB_HSEL], k[CB_REV], k[CB_PIO],
              k[CB_LOOP], ~k[CB_MANUAL_STROBE_BIT]};
   endfunction

   // one-cycle strobes with a gap so no signal is assigned twice per step
   task automatic wr_reg(int p, logic [1:0] i, logic [15:0] d);
      addr <= {p[1:0], i}; wdata <= d; wr <= 1'b1;
      @(posedge ref_clk) wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd_reg(int p, logic [1:0] i);
      addr <= {p[1:0], i}; rd <= 1'b1;
      @(posedge ref_clk) rd <= 1'b0;
      #1 v = rdata;
      @(posedge ref_clk);
   endtask
   task automatic test_done;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // clock, and a watchdog well past the expected run length
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      test_done();
   end

   // main sequence
   initial begin
      rst = 1'b1; wr = 1'b0; rd = 1'b0; dma_wr = 1'b0; addr = 4'h0; wdata = 16'h0000;
      dma = '0; in_byte = 8'h00; busy_len = 8'h14; rnd = 32'hCD72;
      bad_count = 0; comparisons = 0;
      for (int p = 0; p < NPORT; p++) stat_base[p] = 5'h1F;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd_reg(0, REG_CTRL); `CHK(v, CTRL_RST)
      rd_reg(0, REG_WIDTH); `CHK(v, 16'h003F)
      rd_reg(0, REG_STAT); `CHK(v[ST_OBE], 1'b1)
      // status lines of every port read back
      for (int p = 0; p < NPORT; p++) begin
         rnd = lfsr(rnd);
         stat_base[p] <= rnd[4:0];
         repeat (4) @(posedge ref_clk);
         rd_reg(p, REG_STAT);
         `CHK(v[4:0], {rnd[4], rnd[0], rnd[1], rnd[2], 1'b0})
      end
      // each of the six defined mode codes, dma offered only where allowed
      for (int i = 0; i < 6; i++) begin
         wr_reg(3, REG_CTRL, CTRL_RST | 16'h0020 | 16'(codes[i]));
         repeat (4) @(posedge ref_clk);
         rd_reg(3, REG_CTRL); `CHK(v[3:0], codes[i])
         `CHK(dma_req[3], DMA_EXP[i])
      end
      wr_reg(3, REG_CTRL, CTRL_RST);
      // manual mode: firmware toggles controls, latches follow bits
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         c = 16'(MODE_MAN_COMPAT) | (rnd[15:0] & 16'h0FC0);
         wr_reg(i, REG_CTRL, c);
         wr_reg(i, REG_DATA, {8'h00, rnd[23:16]});
         rd_reg(i, REG_STAT); `CHK(v[ST_OBE], 1'b1)
         repeat (100) @(posedge ref_clk);
         `CHK(u_far.ctrl_ff[i[1:0]], ctrl_byte(c))
         `CHK(u_far.data_ff[i[1:0]], rnd[23:16])
      end
      // automatic slow mode on port 1 with a long busy and a refused write
      busy_len <= 8'hC8;
      b1 = {rnd[7:1], 1'b1};
      wr_reg(1, REG_CTRL, CTRL_RST);
      repeat (100) @(posedge ref_clk);
      wr_reg(1, REG_DATA, {8'h00, b1});
      rd_reg(1, REG_STAT); `CHK(v[ST_OBE], 1'b0)
      wr_reg(1, REG_DATA, {8'h00, ~b1});
      n = 0;
      while (u_far.data_ff[1] !== b1 && n < 500) begin @(posedge ref_clk); n++; end
      n = 0;
      while (u_far.ctrl_ff[1][7] !== 1'b0 && n < 2000) begin @(posedge ref_clk); n++; end
      `CHK((n >= 63) && (n < 2000), 1'b1)
      n = 0;
      while (u_far.ctrl_ff[1][7] === 1'b0 && n < 2000) begin @(posedge ref_clk); n++; end
      `CHK((n >= 63) && (n < 2000), 1'b1)
      while (u_far.stat_in[1].busy === 1'b1 && n < 4000) begin @(posedge ref_clk); n++; end
      repeat (3) @(posedge ref_clk);
      `CHK(u_far.data_ff[1], b1)
      n = 0;
      do begin rd_reg(1, REG_STAT); n++; end while (v[ST_OBE] !== 1'b1 && n < 500);
      `CHK(v[ST_OBE], 1'b1)
      // dma write into port 1 once empty
      wr_reg(1, REG_CTRL, CTRL_RST | 16'h0020);
      repeat (3) @(posedge ref_clk);
      `CHK(dma_req[1], 1'b1)
      dma <= '{port: 2'h1, data: ~b1}; dma_wr <= 1'b1;
      @(posedge ref_clk) dma_wr <= 1'b0;
      repeat (3) @(posedge ref_clk);
      `CHK(dma_req[1], 1'b0)
      n = 0;
      while (u_far.data_ff[1] !== ~b1 && n < 500) begin @(posedge ref_clk); n++; end
      `CHK(u_far.data_ff[1], ~b1)
      // byte mode on port 2: inbound read through the read enable
      rnd = lfsr(rnd);
      in_byte <= rnd[7:0];
      wr_reg(2, REG_CTRL, CTRL_RST | 16'(MODE_BYTE));
      repeat (100) @(posedge ref_clk);
      rd_reg(2, REG_DATA); `CHK(v[7:0], rnd[7:0])
      `CHK(u_far.ctrl_ff[2][3], 1'b1)
      // acknowledge fall on port 0 sets the flag and irq; writing one clears both
      stat_base[0] <= 5'h1F;
      wr_reg(0, REG_CTRL, CTRL_RST | (16'h0001 << CB_ACKIE));
      stat_base[0] <= 5'h0F;
      repeat (3) @(posedge ref_clk);
      rd_reg(0, REG_STAT); `CHK(v[ST_ACKF], 1'b1)
      `CHK(irq, 1'b1)
      wr_reg(0, REG_STAT, 16'h0001 << ST_ACKF);
      rd_reg(0, REG_STAT); `CHK(v[ST_ACKF], 1'b0)
      `CHK(irq, 1'b0)
      test_done();
   end
endmodule
